// *** rtl/dsl_top.v ***
// Digital side of a daisy-chained satellite acceleration sensor
`timescale 1ns/1ps
`default_nettype none
`include "dsl_defines.vh"
module dsl_top #(
  parameter ACC_W = `DSL_ACC_W,
  parameter CUST_BITS = `DSL_CUST_BITS,
  parameter FACT_BITS = `DSL_FACT_BITS,
  parameter OSC_DIV = `DSL_OSC_DIV,
  parameter UV_TICKS = `DSL_UV_TICKS
) (
  input wire clock_i,
  input wire nrst_i,
  input wire acc_valid_i,
  input wire [ACC_W-1:0] acc_data_i,
  input wire upstream_bus_port_cmd_valid_i,
  input wire [3:0] upstream_bus_port_cmd_i,
  input wire [7:0] upstream_bus_port_data_i,
  input wire downstream_bus_port_cmd_valid_i,
  input wire [3:0] downstream_bus_port_cmd_i,
  input wire [7:0] downstream_bus_port_data_i,
  output wire cmd_ready_o,
  input wire storage_cap_supply_low_i,
  input wire [FACT_BITS-1:0] otp_factory_i,
  input wire trim_prog_valid_i,
  input wire [6:0] trim_prog_addr_i,
  output reg upstream_bus_port_tx_o,
  output reg upstream_bus_port_tx_en_o,
  output reg downstream_bus_port_tx_o,
  output reg downstream_bus_port_tx_en_o,
  output reg bus_switch_closed_o,
  output reg reverse_mode_o,
  output reg initialized_o,
  output reg parity_fault_o,
  output reg uv_flag_o,
  output reg por_active_o
);
  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  // Counter end points, cut on purpose to the counter widths
  localparam [31:0] DIV_LAST_W = OSC_DIV - 1;
  localparam [31:0] UV_LAST_W = UV_TICKS - 1;
  localparam [4:0] DIV_LAST = DIV_LAST_W[4:0];
  localparam [12:0] UV_LAST = UV_LAST_W[12:0];
  // Short length select code that keeps the previous length
  localparam [1:0] SEL_KEEP = 2'h3;
  // Top bit of the frame shifter, sent first
  localparam integer SHIFT_MSB = `DSL_FRAME_W - 1;

  reg [4:0] div_cnt_ff;
  reg osc_tick_ff;
  reg [12:0] uv_cnt_ff;
  reg [ACC_W-1:0] acc_ff;
  reg [CUST_BITS-1:0] cust_otp_ff;
  reg [1:0] short_sel_ff;
  reg [10:0] shift_ff;
  reg [3:0] bits_left_ff;
  reg busy_ff;
  reg port_ff;

  reg rx_valid;
  reg [3:0] rx_cmd;
  reg [7:0] rx_data;
  reg rx_down;
  reg resp_valid;
  reg [`DSL_BUF_W-1:0] resp_word;
  reg [ACC_W-1:0] acc_resp;
  reg [3:0] short_len;
  reg [7:0] otp_byte;

  wire take;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [`DSL_BUF_W-1:0] buf_out_data;
  wire pop;
  wire fact_fault;
  wire cust_fault;
  wire [`DSL_OTP_BITS-1:0] otp_image;
  wire uv_timeout;
  wire is_init;
  wire [3:0] pop_len;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Keep the top len bits of a result, zero the rest
  function [ACC_W-1:0] top_bits;
    input [ACC_W-1:0] val;
    input [3:0] len;
    reg [ACC_W-1:0] mask;
    begin
      mask = {ACC_W{1'b1}} << (`DSL_LEN_LONG - len);
      top_bits = val & mask;
    end
  endfunction

  // ------------------------------------------------------------------
  // Oscillator tick
  // ------------------------------------------------------------------
  // Divide the system clock to the 4 MHz oscillator rate
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt_ff <= 5'h00;
      osc_tick_ff <= 1'b0;
    end else begin
      osc_tick_ff <= (div_cnt_ff == DIV_LAST);
      if (div_cnt_ff == DIV_LAST) begin
        div_cnt_ff <= 5'h00;
      end else begin
        div_cnt_ff <= div_cnt_ff + 5'h01;
      end
    end
  end

  // ------------------------------------------------------------------
  // Undervoltage supervision
  // ------------------------------------------------------------------
  // Timeout fires on the tick that finds the count at its last value
  assign uv_timeout = storage_cap_supply_low_i & osc_tick_ff & (uv_cnt_ff == UV_LAST);

  // Count low-supply time in ticks, restart on recovery
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      uv_cnt_ff <= 13'h0000;
      uv_flag_o <= 1'b0;
      por_active_o <= 1'b0;
    end else begin
      uv_flag_o <= storage_cap_supply_low_i;
      if (!storage_cap_supply_low_i) begin
        uv_cnt_ff <= 13'h0000;
      end else if (osc_tick_ff && uv_cnt_ff != UV_LAST) begin
        uv_cnt_ff <= uv_cnt_ff + 13'h0001;
      end
      if (uv_timeout) begin
        por_active_o <= 1'b1;
      end else if (!storage_cap_supply_low_i) begin
        por_active_o <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // One-time programmable storage and parity
  // ------------------------------------------------------------------
  // Full image and per-region parity, even over each region
  assign otp_image = {cust_otp_ff, otp_factory_i};
  assign fact_fault = ^otp_factory_i;
  assign cust_fault = ^cust_otp_ff;

  // Customer bits only go from 0 to 1, except that nrst_i clears them
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cust_otp_ff <= {CUST_BITS{1'b0}};
      parity_fault_o <= 1'b0;
    end else begin
      parity_fault_o <= fact_fault | cust_fault;
      if (!por_active_o) begin
        if (take && rx_cmd == `DSL_CMD_OTP_WRITE &&
            rx_data[`DSL_OTP_ADDR_MSB:0] < CUST_BITS) begin
          cust_otp_ff[rx_data[`DSL_OTP_ADDR_MSB:0]] <= 1'b1;
        end
        if (trim_prog_valid_i && trim_prog_addr_i < CUST_BITS) begin
          cust_otp_ff[trim_prog_addr_i] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Acceleration sample
  // ------------------------------------------------------------------
  // Hold the latest converted result
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_ff <= {ACC_W{1'b0}};
    end else if (acc_valid_i) begin
      acc_ff <= acc_data_i;
    end
  end

  // ------------------------------------------------------------------
  // Command selection
  // ------------------------------------------------------------------
  // Pick the port that faces the master
  always @* begin
    rx_valid = 1'b0;
    rx_cmd = upstream_bus_port_cmd_i;
    rx_data = upstream_bus_port_data_i;
    rx_down = 1'b0;
    if (!initialized_o) begin
      if (upstream_bus_port_cmd_valid_i && upstream_bus_port_cmd_i == `DSL_CMD_INIT) begin
        rx_valid = 1'b1;
      end else if (downstream_bus_port_cmd_valid_i &&
                   downstream_bus_port_cmd_i == `DSL_CMD_REV_INIT) begin
        rx_valid = 1'b1;
        rx_cmd = downstream_bus_port_cmd_i;
        rx_data = downstream_bus_port_data_i;
        rx_down = 1'b1;
      end
    end else if (reverse_mode_o) begin
      rx_valid = downstream_bus_port_cmd_valid_i;
      rx_cmd = downstream_bus_port_cmd_i;
      rx_data = downstream_bus_port_data_i;
      rx_down = 1'b1;
    end else begin
      rx_valid = upstream_bus_port_cmd_valid_i;
    end
  end

  // A command is taken only with buffer room and outside reset
  assign take = rx_valid & buf_in_ready & ~por_active_o;
  assign cmd_ready_o = buf_in_ready;
  assign is_init = (rx_cmd == `DSL_CMD_INIT) | (rx_cmd == `DSL_CMD_REV_INIT);

  // ------------------------------------------------------------------
  // Link state
  // ------------------------------------------------------------------
  // Mode, switch and short length after initialization
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      initialized_o <= 1'b0;
      reverse_mode_o <= 1'b0;
      bus_switch_closed_o <= 1'b0;
      short_sel_ff <= 2'h0;
    end else if (uv_timeout || por_active_o) begin
      initialized_o <= 1'b0;
      reverse_mode_o <= 1'b0;
      bus_switch_closed_o <= 1'b0;
      short_sel_ff <= 2'h0;
    end else if (take && is_init) begin
      initialized_o <= 1'b1;
      reverse_mode_o <= rx_down;
      bus_switch_closed_o <= rx_data[`DSL_SWITCH_CLOSE_BIT];
      if (rx_data[`DSL_SHORT_LEN_LSB+1:`DSL_SHORT_LEN_LSB] != SEL_KEEP) begin
        short_sel_ff <= rx_data[`DSL_SHORT_LEN_LSB+1:`DSL_SHORT_LEN_LSB];
      end
    end
  end

  // ------------------------------------------------------------------
  // Response builder
  // ------------------------------------------------------------------
  // Form the answer word for each accepted command with code 0 to 5
  always @* begin
    short_len = `DSL_LEN_SHORT_MIN + {2'h0, short_sel_ff};
    otp_byte = otp_image[rx_data[`DSL_OTP_BYTE_MSB:0]*8 +: 8];
    acc_resp = acc_ff;
    // Parity fault blanks every acceleration answer
    if (parity_fault_o) begin
      acc_resp = {ACC_W{1'b0}};
    end
    resp_valid = 1'b0;
    // Echo word unless a command below replaces it
    resp_word = {rx_down, uv_flag_o, `DSL_LEN_ECHO, rx_data, 2'h0};
    case (rx_cmd)
      `DSL_CMD_INIT, `DSL_CMD_REV_INIT, `DSL_CMD_OTP_WRITE: begin
        resp_valid = take;
      end
      `DSL_CMD_OTP_READ: begin
        resp_valid = take;
        resp_word = {rx_down, uv_flag_o, `DSL_LEN_ECHO, otp_byte, 2'h0};
      end
      `DSL_CMD_READ_SHORT: begin
        resp_valid = take;
        if (uv_flag_o) begin
          acc_resp = {ACC_W{1'b0}};
        end
        resp_word = {rx_down, uv_flag_o, short_len, top_bits(acc_resp, short_len)};
      end
      `DSL_CMD_READ_LONG: begin
        resp_valid = take;
        resp_word = {rx_down, uv_flag_o, `DSL_LEN_LONG, acc_resp};
      end
      default: begin
        resp_valid = 1'b0;
      end
    endcase
  end

  // Responses wait here while the serialiser is busy
  dsl_pair_buf #(
    .W(`DSL_BUF_W)
  ) u_buf (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .flush_i(por_active_o),
    .in_valid_i(resp_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(resp_word),
    .out_valid_o(buf_out_valid),
    .out_ready_i(pop),
    .out_data_o(buf_out_data)
  );

  // ------------------------------------------------------------------
  // Serialiser
  // ------------------------------------------------------------------
  // Start a frame when the serialiser is idle, a word is waiting and reset is off
  assign pop = buf_out_valid & ~busy_ff & ~por_active_o;
  // Frame length field of the word at the buffer head
  assign pop_len = buf_out_data[`DSL_BUF_LEN_MSB:`DSL_BUF_LEN_LSB];

  // Flag bit first, then payload MSB first, one bit per tick
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_ff <= 11'h000;
      bits_left_ff <= 4'h0;
      busy_ff <= 1'b0;
      port_ff <= 1'b0;
    end else if (por_active_o) begin
      busy_ff <= 1'b0;
      bits_left_ff <= 4'h0;
    end else if (pop) begin
      busy_ff <= 1'b1;
      port_ff <= buf_out_data[`DSL_BUF_PORT];
      shift_ff <= {buf_out_data[`DSL_BUF_UV], buf_out_data[ACC_W-1:0]};
      bits_left_ff <= pop_len + 4'h1;
    end else if (busy_ff && osc_tick_ff) begin
      shift_ff <= {shift_ff[SHIFT_MSB-1:0], 1'b0};
      bits_left_ff <= bits_left_ff - 4'h1;
      if (bits_left_ff == 4'h1) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // Drive the bit onto the port facing the master
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      upstream_bus_port_tx_o <= 1'b0;
      upstream_bus_port_tx_en_o <= 1'b0;
      downstream_bus_port_tx_o <= 1'b0;
      downstream_bus_port_tx_en_o <= 1'b0;
    end else begin
      // Enables drop with reset so the ports go quiet at once
      upstream_bus_port_tx_o <= busy_ff & ~port_ff & shift_ff[SHIFT_MSB];
      upstream_bus_port_tx_en_o <= busy_ff & ~port_ff & ~por_active_o;
      downstream_bus_port_tx_o <= busy_ff & port_ff & shift_ff[SHIFT_MSB];
      downstream_bus_port_tx_en_o <= busy_ff & port_ff & ~por_active_o;
    end
  end
endmodule // dsl_top
`default_nettype wire

// *** rtl/dsl_defines.vh ***
// Constants for the satellite sensor link block
// Functional notes
// - The latest converted acceleration word is shifted out serially to the master on a read command.
// - Results are 10 bits; response payload length is 8 to 10 bits.
// - 128 bits of one-time programmable storage hold trim, serial number, characteristics.
// - 80 customer bits, programmable over the bus or the test/trim port.
// - Storage integrity is checked by parity continuously, every cycle.
// - Factory and customer regions each carry and check their own parity.
// - Any parity fault forces acceleration read answers to zero.
// - Supply undervoltage: short acceleration reads answer zero, undervoltage flag set.
// - Undervoltage over one millisecond forces reset; silent until recovery and re-init.
// - Daisy-chain switch is open after every reset.
// - Init or reverse init with switch close bit set closes the switch.
// - Reverse init: commands accepted and answered on the downstream port.
// - In reverse mode the upstream port leads on to further devices.
// - Normal mode: master talks on upstream port, downstream passes the chain.
// - Timing comes from a 4 MHz oscillator tick.
`ifndef DSL_DEFINES_VH
`define DSL_DEFINES_VH

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define DSL_CLK_KHZ 100000
`define DSL_OSC_KHZ 4000
`define DSL_OSC_DIV (`DSL_CLK_KHZ / `DSL_OSC_KHZ)
`define DSL_UV_TIMEOUT_US 1000
`define DSL_UV_TICKS ((`DSL_UV_TIMEOUT_US * `DSL_OSC_KHZ) / 1000)

// ------------------------------------------------------------------
// Widths and sizes
// ------------------------------------------------------------------
`define DSL_ACC_W 10
`define DSL_OTP_BITS 128
`define DSL_CUST_BITS 80
`define DSL_FACT_BITS 48
`define DSL_LEN_SHORT_MIN 4'h8
`define DSL_LEN_LONG 4'ha
`define DSL_LEN_ECHO 4'h8
`define DSL_FRAME_W 11

// ------------------------------------------------------------------
// Command codes
// ------------------------------------------------------------------
`define DSL_CMD_INIT 4'h0
`define DSL_CMD_REV_INIT 4'h1
`define DSL_CMD_READ_SHORT 4'h2
`define DSL_CMD_READ_LONG 4'h3
`define DSL_CMD_OTP_READ 4'h4
`define DSL_CMD_OTP_WRITE 4'h5

// ------------------------------------------------------------------
// Command data fields
// ------------------------------------------------------------------
`define DSL_SWITCH_CLOSE_BIT 6
`define DSL_SHORT_LEN_LSB 4
`define DSL_OTP_ADDR_MSB 6
`define DSL_OTP_BYTE_MSB 3

// ------------------------------------------------------------------
// Buffer word layout
// ------------------------------------------------------------------
`define DSL_BUF_W 16
`define DSL_BUF_PORT 15
`define DSL_BUF_UV 14
`define DSL_BUF_LEN_MSB 13
`define DSL_BUF_LEN_LSB 10

`endif

// *** rtl/dsl_pair_buf.v ***
// Two-entry buffer between response builder and serialiser
`timescale 1ns/1ps
`default_nettype none
module dsl_pair_buf #(
  parameter W = 16
) (
  input wire clock_i,
  input wire nrst_i,
  input wire flush_i,
  input wire in_valid_i,
  output reg in_ready_o,
  input wire [W-1:0] in_data_i,
  output reg out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] mem_ff [0:1];
  reg wr_ptr_ff;
  reg rd_ptr_ff;
  reg [1:0] count_ff;
  reg [1:0] nxt_count;
  wire push;
  wire pop;

  // Handshakes on both sides
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_ff[rd_ptr_ff];

  // Occupancy after this cycle
  always @* begin
    nxt_count = count_ff;
    if (push & ~pop) begin
      nxt_count = count_ff + 2'h1;
    end else if (pop & ~push) begin
      nxt_count = count_ff - 2'h1;
    end
    if (flush_i) begin
      nxt_count = 2'h0;
    end
  end

  // Pointers, occupancy and registered flags
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      in_ready_o <= (nxt_count != 2'h2);
      out_valid_o <= (nxt_count != 2'h0);
      if (flush_i) begin
        wr_ptr_ff <= 1'b0;
        rd_ptr_ff <= 1'b0;
      end else begin
        if (push) begin
          wr_ptr_ff <= ~wr_ptr_ff;
        end
        if (pop) begin
          rd_ptr_ff <= ~rd_ptr_ff;
        end
      end
    end
  end

  // Storage, written without reset
  always @(posedge clock_i) begin
    if (push & ~flush_i) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end
endmodule // dsl_pair_buf
`default_nettype wire

// *** dv/dsl_props.sv ***
// Port checks for the satellite sensor link top
`timescale 1ns/1ps
`default_nettype none
module dsl_props #(
  parameter FACT_BITS = 48,
  parameter OSC_DIV = 25,
  parameter UV_TICKS = 4000
) (
  input wire clock_i,
  input wire nrst_i,
  input wire storage_cap_supply_low_i,
  input wire [FACT_BITS-1:0] otp_factory_i,
  input wire upstream_bus_port_tx_en_o,
  input wire downstream_bus_port_tx_en_o,
  input wire bus_switch_closed_o,
  input wire reverse_mode_o,
  input wire initialized_o,
  input wire parity_fault_o,
  input wire uv_flag_o,
  input wire por_active_o,
  input wire cmd_ready_o
);
  int low_ff;
  int txh_ff;
  wire tx_any = upstream_bus_port_tx_en_o | downstream_bus_port_tx_en_o;
  // Cycles of low supply and of frame length
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_ff <= 0;
      txh_ff <= 0;
    end else begin
      low_ff <= storage_cap_supply_low_i ? low_ff + 1 : 0;
      txh_ff <= tx_any ? txh_ff + 1 : 0;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  por_early_a: assert property ($rose(por_active_o) |-> low_ff >= (UV_TICKS - 1) * OSC_DIV)
    else $error("reset before timeout");
  por_late_a: assert property (low_ff == (UV_TICKS + 1) * OSC_DIV + 3 |-> por_active_o)
    else $error("reset missing after timeout");
  por_release_a: assert property ($fell(storage_cap_supply_low_i) |=> !por_active_o)
    else $error("reset kept after recovery");
  por_quiet_a: assert property (por_active_o |=> !tx_any)
    else $error("answer during reset");
  por_open_a: assert property (por_active_o |=> !bus_switch_closed_o && !initialized_o)
    else $error("switch or init kept in reset");
  sw_needs_init_a: assert property (!initialized_o |-> !bus_switch_closed_o)
    else $error("switch closed without init");
  uv_flag_a: assert property ($rose(storage_cap_supply_low_i) |=> uv_flag_o)
    else $error("undervoltage flag late");
  one_port_a: assert property (!(upstream_bus_port_tx_en_o && downstream_bus_port_tx_en_o))
    else $error("both ports driven");
  rev_port_a: assert property (reverse_mode_o |-> !upstream_bus_port_tx_en_o)
    else $error("upstream answer in reverse mode");
  fwd_port_a: assert property (!reverse_mode_o && !$past(reverse_mode_o)
    |-> !downstream_bus_port_tx_en_o)
    else $error("downstream answer in normal mode");
  frame_len_a: assert property (txh_ff <= 12 * OSC_DIV + 2)
    else $error("frame too long");
  parity_a: assert property (^otp_factory_i |-> ##[0:2] parity_fault_o)
    else $error("factory parity fault missed");
  cover property ($rose(por_active_o));
  cover property ($rose(reverse_mode_o));
  cover property ($fell(cmd_ready_o));
endmodule // dsl_props
`default_nettype wire

// *** dv/dsl_master_model.sv ***
// Bus master model: issues commands and records answer frames
`timescale 1ns/1ps
`default_nettype none
module dsl_master_model (
  input wire logic clock_i,
  input wire logic cmd_ready_i,
  input wire logic up_tx_i,
  input wire logic up_tx_en_i,
  input wire logic dn_tx_i,
  input wire logic dn_tx_en_i,
  output logic up_vld_o,
  output logic [3:0] up_cmd_o,
  output logic [7:0] up_dat_o,
  output logic dn_vld_o,
  output logic [3:0] dn_cmd_o,
  output logic [7:0] dn_dat_o
);
  logic [63:0] q_s[$];
  int q_t[$];
  bit q_p[$];
  logic [63:0] s = '0;
  int t = 0;
  bit p = 0;
  // Lines idle at time zero
  initial begin
    {up_vld_o, up_cmd_o, up_dat_o} = '0;
    {dn_vld_o, dn_cmd_o, dn_dat_o} = '0;
  end
  // One sample a cycle of the answering port
  always @(posedge clock_i) begin
    if ((up_tx_en_i || dn_tx_en_i) && t < 64) begin
      s[t] = up_tx_en_i ? up_tx_i : dn_tx_i;
      p = dn_tx_en_i;
      t = t + 1;
    end else if (t > 0) begin
      q_s.push_back(s);
      q_t.push_back(t);
      q_p.push_back(p);
      t = 0;
    end
  end
  // Hold a command until taken, or for a fixed span
  task automatic send(input bit dn, input logic [3:0] c, input logic [7:0] d, input int hold);
    int n;
    n = 0;
    @(negedge clock_i);
    if (dn) {dn_vld_o, dn_cmd_o, dn_dat_o} = {1'b1, c, d};
    else {up_vld_o, up_cmd_o, up_dat_o} = {1'b1, c, d};
    do begin
      @(posedge clock_i);
      n++;
    end while (hold > 0 ? n < hold : (cmd_ready_i !== 1'b1 && n < 300));
    if (n >= 300) begin
      tb_top.n_fail++;
      tb_top.final_report();
    end
    @(negedge clock_i);
    // Released lines show the inverse, not a stale command
    if (dn) {dn_vld_o, dn_cmd_o, dn_dat_o} = {1'b0, ~c, ~d};
    else {up_vld_o, up_cmd_o, up_dat_o} = {1'b0, ~c, ~d};
  endtask
endmodule // dsl_master_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the satellite sensor link top
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int O = 4;
  localparam logic [47:0] FACT = 48'h0000_0000_0c35;
  logic clock_i, nrst_i, acc_v, low, trim_v, saw_full;
  logic [9:0] acc_d;
  logic [47:0] fact;
  logic [6:0] trim_a;
  wire up_v, dn_v, rdy, up_tx, up_en, dn_tx, dn_en, sw, rev, init, pf, uv, por;
  wire [3:0] up_c, dn_c;
  wire [7:0] up_d, dn_d;
  int n_fail = 0;
  int total_checks = 0;
  dsl_top #(.OSC_DIV(O), .UV_TICKS(100)) u_dut (.clock_i(clock_i), .nrst_i(nrst_i),
    .acc_valid_i(acc_v), .acc_data_i(acc_d), .upstream_bus_port_cmd_valid_i(up_v),
    .upstream_bus_port_cmd_i(up_c), .upstream_bus_port_data_i(up_d),
    .downstream_bus_port_cmd_valid_i(dn_v), .downstream_bus_port_cmd_i(dn_c),
    .downstream_bus_port_data_i(dn_d), .cmd_ready_o(rdy), .storage_cap_supply_low_i(low),
    .otp_factory_i(fact), .trim_prog_valid_i(trim_v), .trim_prog_addr_i(trim_a),
    .upstream_bus_port_tx_o(up_tx), .upstream_bus_port_tx_en_o(up_en),
    .downstream_bus_port_tx_o(dn_tx), .downstream_bus_port_tx_en_o(dn_en),
    .bus_switch_closed_o(sw), .reverse_mode_o(rev), .initialized_o(init),
    .parity_fault_o(pf), .uv_flag_o(uv), .por_active_o(por));
  dsl_master_model u_mst (.clock_i(clock_i), .cmd_ready_i(rdy), .up_tx_i(up_tx),
    .up_tx_en_i(up_en), .dn_tx_i(dn_tx), .dn_tx_en_i(dn_en), .up_vld_o(up_v),
    .up_cmd_o(up_c), .up_dat_o(up_d), .dn_vld_o(dn_v), .dn_cmd_o(dn_c), .dn_dat_o(dn_d));
  // Clock and full-buffer monitor
  initial begin
    clock_i = 0;
    forever #5 clock_i = ~clock_i;
  end
  always @(negedge clock_i) if (rdy === 1'b0) saw_full = 1;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Pop one frame; flag first, payload bits mid-bit from the end
  task automatic frame(input bit p, input bit f, input logic [15:0] v, input int len);
    int n;
    int t;
    logic [63:0] s;
    logic [15:0] got;
    n = 0;
    while (u_mst.q_t.size() == 0 && n < 400) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 400) begin
      n_fail++;
      final_report();
    end
    s = u_mst.q_s.pop_front();
    t = u_mst.q_t.pop_front();
    chk("port", p, u_mst.q_p.pop_front());
    chk("flag", f, s[0]);
    got = '0;
    for (int j = 0; j < len; j++) got[j] = s[t - 1 - O / 2 - O * j];
    chk("payload", v, got);
  endtask
  task automatic none();
    repeat (80) @(negedge clock_i);
    chk("frames", 0, u_mst.q_t.size());
  endtask
  task automatic do_reset();
    nrst_i = 0;
    repeat (6) @(negedge clock_i);
    nrst_i = 1;
  endtask
  task automatic acc(input logic [9:0] v);
    @(negedge clock_i);
    {acc_v, acc_d} = {1'b1, v};
    @(negedge clock_i);
    acc_v = 0;
  endtask
  task automatic t_fwd();
    chk("switch", 0, sw);
    u_mst.send(0, 4'h0, 8'h50, 0);
    frame(0, 0, 16'h50, 8);
    chk("switch", 1, sw);
    acc(10'h2a5);
    u_mst.send(0, 4'h3, 8'h00, 0);
    frame(0, 0, 16'h2a5, 10);
    u_mst.send(0, 4'h2, 8'h00, 0);
    frame(0, 0, 16'h152, 9);
    u_mst.send(1, 4'h3, 8'h00, 5);
    none();
    $display("forward test done");
  endtask
  task automatic t_buf();
    saw_full = 0;
    repeat (4) u_mst.send(0, 4'h3, 8'h00, 0);
    chk("buffer full", 1, saw_full);
    repeat (4) frame(0, 0, 16'h2a5, 10);
    $display("buffer test done");
  endtask
  task automatic t_uv();
    low = 1;
    u_mst.send(0, 4'h2, 8'h00, 0);
    frame(0, 1, 16'h0, 9);
    u_mst.send(0, 4'h3, 8'h00, 0);
    frame(0, 1, 16'h2a5, 10);
    low = 0;
    u_mst.send(0, 4'h2, 8'h00, 0);
    frame(0, 0, 16'h152, 9);
    $display("undervoltage test done");
  endtask
  task automatic t_por();
    int n;
    n = 0;
    low = 1;
    while (por !== 1'b1 && n < 600) begin
      @(negedge clock_i);
      n++;
    end
    chk("por", 1, por);
    if (n >= 600) final_report();
    chk("switch", 0, sw);
    u_mst.send(0, 4'h0, 8'h40, 5);
    none();
    low = 0;
    repeat (2) @(negedge clock_i);
    chk("por", 0, por);
    u_mst.send(0, 4'h3, 8'h00, 5);
    none();
    u_mst.send(0, 4'h0, 8'h40, 0);
    frame(0, 0, 16'h40, 8);
    low = 1;
    repeat (300) @(negedge clock_i);
    low = 0;
    @(negedge clock_i);
    low = 1;
    repeat (300) @(negedge clock_i);
    chk("por", 0, por);
    low = 0;
    $display("reset test done");
  endtask
  task automatic t_otp();
    u_mst.send(0, 4'h4, 8'h00, 0);
    frame(0, 0, 16'h35, 8);
    fact = FACT ^ 48'h1;
    repeat (3) @(negedge clock_i);
    chk("parity", 1, pf);
    u_mst.send(0, 4'h3, 8'h00, 0);
    frame(0, 0, 16'h0, 10);
    fact = FACT;
    repeat (3) @(negedge clock_i);
    chk("parity", 0, pf);
    u_mst.send(0, 4'h5, 8'h55, 0);
    frame(0, 0, 16'h55, 8);
    u_mst.send(0, 4'h5, 8'h00, 0);
    frame(0, 0, 16'h0, 8);
    u_mst.send(0, 4'h4, 8'h06, 0);
    frame(0, 0, 16'h1, 8);
    chk("parity", 1, pf);
    u_mst.send(0, 4'h3, 8'h00, 0);
    frame(0, 0, 16'h0, 10);
    {trim_v, trim_a} = {1'b1, 7'd9};
    @(negedge clock_i);
    trim_v = 0;
    u_mst.send(0, 4'h4, 8'h07, 0);
    frame(0, 0, 16'h2, 8);
    $display("storage test done");
  endtask
  task automatic t_rev();
    do_reset();
    acc(10'h3ff);
    u_mst.send(0, 4'h3, 8'h00, 5);
    none();
    u_mst.send(1, 4'h1, 8'h40, 0);
    frame(1, 0, 16'h40, 8);
    chk("reverse", 1, rev);
    chk("switch", 1, sw);
    u_mst.send(0, 4'h3, 8'h00, 5);
    none();
    u_mst.send(1, 4'h3, 8'h00, 0);
    frame(1, 0, 16'h3ff, 10);
    $display("reverse test done");
  endtask
  // Main sequence
  initial begin
    {acc_v, acc_d, low, trim_v, trim_a, saw_full} = '0;
    fact = FACT;
    do_reset();
    t_fwd();
    t_buf();
    t_uv();
    t_por();
    t_otp();
    t_rev();
    final_report();
  end
endmodule // tb_top
bind dsl_top dsl_props #(.FACT_BITS(FACT_BITS), .OSC_DIV(OSC_DIV), .UV_TICKS(UV_TICKS))
  u_props (.clock_i, .nrst_i, .storage_cap_supply_low_i, .otp_factory_i,
  .upstream_bus_port_tx_en_o, .downstream_bus_port_tx_en_o, .bus_switch_closed_o,
  .reverse_mode_o, .initialized_o, .parity_fault_o, .uv_flag_o, .por_active_o, .cmd_ready_o);
`default_nettype wire
